// ===== verilog/qrl_pkg.sv
// Purpose: Constants for the top-queue rate limit selection block.
// Assumes: 32-bit APB, byte address is four times the register index.
// Notes: Register indices, field layout and timing counts.
// Function
// - Top-queue 7-bit limit code, reset zero, shapes.
// - Queue 3 is highest in four-queue mode.
// - Bit 7 read-only; port 4 shows identification.
// - Exact rate on top; others by ratio.
// - Same 7-bit code format for all limits.
// - 100BT codes 1-99 give that Mbps.
// - 100BT code 0 or 100 unlimited.
// - Codes 101-115 give 64 kbps steps.
// - 10BT codes 1-9 give that Mbps.
// - 10BT code 0 or 10 unlimited.
// - Speed bit set selects 10BT table.
package qrl_pkg;

  // Bus widths
  localparam int unsigned APB_AW = 10;
  localparam int unsigned APB_DW = 32;
  localparam int unsigned NUM_PORTS = 4;

  // Register indices; byte address is four times these
  localparam logic [7:0] IDX_RSVD_BE = 8'hbe;
  localparam logic [7:0] IDX_P1_LIMIT = 8'hce;
  localparam logic [7:0] IDX_P2_LIMIT = 8'hde;
  localparam logic [7:0] IDX_P3_LIMIT = 8'hee;
  localparam logic [7:0] IDX_P4_LIMIT = 8'hfe;
  localparam logic [7:0] IDX_PORT_MODE = 8'h40;
  localparam logic [7:0] IDX_SHAPE_STAT = 8'h41;

  // Field layout of the limit registers
  localparam int unsigned LIMIT_W = 7;
  localparam int unsigned ID_BIT = 7;
  localparam logic [6:0] LIMIT_RST = 7'h00;

  // Field layout of the port mode register
  localparam int unsigned SPEED_LSB = 0;
  localparam int unsigned FOURQ_LSB = 4;
  localparam logic [3:0] SPEED_RST = 4'h0;
  localparam logic [3:0] FOURQ_RST = 4'h0;

  // Limit code values
  localparam logic [6:0] CODE_DEFAULT = 7'd0;
  localparam logic [6:0] CODE_FULL_100 = 7'd100;
  localparam logic [6:0] CODE_FULL_10 = 7'd10;
  localparam logic [6:0] CODE_SUB_FIRST = 7'd101;
  localparam logic [6:0] CODE_SUB_LAST = 7'd115;
  localparam logic [6:0] CODE_SUB_BASE = 7'd100;

  // Rates in kbps
  localparam int unsigned RATE_W = 17;
  localparam logic [16:0] KBPS_PER_MBPS = 17'd1000;
  localparam logic [16:0] SUB_STEP_KBPS = 17'd64;

  // Timing: credit is added once per tick
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_CW = 8;

  // Credit in millibits; kbps equals millibits per microsecond
  localparam int unsigned CREDIT_W = 26;
  localparam logic [25:0] MBIT_PER_BYTE = 26'd8000;
  localparam logic [25:0] CREDIT_CAP = 26'd16000000;

  // Byte address of a register index
  function automatic logic [APB_AW-1:0] qrl_addr(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction

endpackage

// ===== verilog/qrl_rate_decode.sv
// Purpose: Decode a 7-bit limit code into a rate or no limiting.
// Assumes: speed_10 high selects the 10BT table.
// Notes: Purely combinational; shared by every limit of a port.
`timescale 1ns/1ps

module qrl_rate_decode
  import qrl_pkg::*;
(
  // Selection
  input wire logic [qrl_pkg::LIMIT_W-1:0] code,
  input wire logic speed_10,
  // Result
  output logic unlimited,
  output logic [qrl_pkg::RATE_W-1:0] rate_kbps
);

  // Upper limit of the whole-Mbps range for the active speed
  logic [6:0] full_code;

  // Table selection and code decode
  always_comb begin
    full_code = speed_10 ? CODE_FULL_10 : CODE_FULL_100;
    unlimited = 1'b1;
    rate_kbps = '0;
    if (code == CODE_DEFAULT || code == full_code) begin
      // Full line rate
      unlimited = 1'b1;
    end else if (code < full_code) begin
      // Whole megabits per second
      unlimited = 1'b0;
      rate_kbps = RATE_W'(code) * KBPS_PER_MBPS;
    end else if (code >= CODE_SUB_FIRST && code <= CODE_SUB_LAST) begin
      // Sub-megabit steps, same at both speeds
      unlimited = 1'b0;
      rate_kbps = RATE_W'(code - CODE_SUB_BASE) * SUB_STEP_KBPS;
    end else begin
      // Undefined code
      unlimited = 1'b1;
    end
  end

endmodule

// ===== verilog/qrl_shaper.sv
// Purpose: Credit shaper for one port's top egress queue.
// Assumes: tick pulses once per microsecond; tx_byte per sent byte.
// Notes: Credit may go negative while a frame drains.
`timescale 1ns/1ps

module qrl_shaper
  import qrl_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic tick,
  input wire logic unlimited,
  input wire logic [qrl_pkg::RATE_W-1:0] rate_kbps,
  input wire logic tx_byte,
  // Status
  output logic eligible
);

  // Signed credit in millibits
  logic signed [CREDIT_W-1:0] credit_reg;
  logic signed [CREDIT_W-1:0] credit_next;
  logic eligible_reg;
  logic eligible_next;
  logic signed [CREDIT_W-1:0] sum;

  // Credit update
  always_comb begin
    sum = credit_reg;
    if (tick) begin
      sum = sum + $signed(CREDIT_W'(rate_kbps));
    end
    if (tx_byte) begin
      sum = sum - $signed(MBIT_PER_BYTE);
    end
    if (unlimited || sum > $signed(CREDIT_CAP)) begin
      credit_next = $signed(CREDIT_CAP);
    end else if (sum < -$signed(CREDIT_CAP)) begin
      credit_next = -$signed(CREDIT_CAP);
    end else begin
      credit_next = sum;
    end
    eligible_next = unlimited || (credit_next > 0);
  end

  // Credit registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      credit_reg <= '0;
      eligible_reg <= 1'b1;
    end else begin
      credit_reg <= credit_next;
      eligible_reg <= eligible_next;
    end
  end

  assign eligible = eligible_reg;

endmodule

// ===== verilog/qrl_top.sv
// Purpose: Top-queue egress limit registers, rate decode and gating.
// Assumes: APB slave on pclk; queue logic on the same clock.
// Notes: Grants are registered and follow requests by one cycle.
//   Every transfer has one access cycle; unmapped words answer with
//   an error. Credit refill runs on a microsecond tick made here,
//   shared by all four shapers.
`timescale 1ns/1ps

module qrl_top
  import qrl_pkg::*;
#(
  // Arbitrary identification bit for the port 4 register
  parameter logic ID_VALUE = 1'b0
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  // Answers come in the cycle after setup, with no wait states
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [qrl_pkg::APB_AW-1:0] paddr,
  input wire logic [qrl_pkg::APB_DW-1:0] pwdata,
  output logic [qrl_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Queue status, one bit per port
  // Levels and byte pulses from the queue logic on pclk
  input wire logic [qrl_pkg::NUM_PORTS-1:0] q3_pending,
  input wire logic [qrl_pkg::NUM_PORTS-1:0] q3_tx_byte,
  input wire logic [qrl_pkg::NUM_PORTS-1:0] low_pending,
  // Service grants, one bit per port
  // Levels, registered and re-evaluated every cycle
  output logic [qrl_pkg::NUM_PORTS-1:0] q3_grant,
  output logic [qrl_pkg::NUM_PORTS-1:0] low_grant
);

  // Register map, byte address four times the index:
  //   limit words of ports 1 to 4, code in bits 6 to 0 and a
  //   read-only bit 7 (identification on port 4, zero elsewhere);
  //   port mode word, speed bits low and four-queue bits high;
  //   status word, eligible bits low and unlimited bits high;
  //   one reserved word that reads zero and ignores writes.
  // Any other word answers with an error and changes nothing.

  // Limit codes, one per port
  logic [LIMIT_W-1:0] limit_reg [NUM_PORTS];
  logic [LIMIT_W-1:0] limit_next [NUM_PORTS];

  // Speed: set is 10BT
  logic [NUM_PORTS-1:0] speed_reg;
  logic [NUM_PORTS-1:0] speed_next;

  // Four-queue mode per port
  logic [NUM_PORTS-1:0] fourq_reg;
  logic [NUM_PORTS-1:0] fourq_next;

  // Bus answer registers
  logic [APB_DW-1:0] prdata_reg;
  logic [APB_DW-1:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;

  // Grant registers
  logic [NUM_PORTS-1:0] q3_grant_reg;
  logic [NUM_PORTS-1:0] q3_grant_next;
  logic [NUM_PORTS-1:0] low_grant_reg;
  logic [NUM_PORTS-1:0] low_grant_next;

  // Tick counter
  // One pulse every microsecond feeds every shaper
  logic [TICK_CW-1:0] tick_cnt_reg;
  logic [TICK_CW-1:0] tick_cnt_next;
  logic tick_reg;
  logic tick_next;

  // Per-port shaper links
  // Decoder output feeds the shaper of the same port
  logic [NUM_PORTS-1:0] unl;
  logic [NUM_PORTS-1:0] elig;
  logic [RATE_W-1:0] rate [NUM_PORTS];

  // Address decode
  logic [1:0] port_sel;
  logic hit_limit;
  logic hit_mode;
  logic hit_stat;
  logic hit_rsvd;
  logic setup;
  logic access;

  // Setup and access phases of a transfer
  // The answer is prepared in setup, so the access phase always
  // lasts one cycle; access is true only in that cycle, which keeps
  // a write from landing twice.
  assign setup = psel && !penable;
  assign access = psel && penable && pready_reg;

  // Address decode for the mapped registers
  // A miss leaves the port index at zero; hit_limit gates every use
  always_comb begin
    hit_limit = 1'b1;
    port_sel = 2'd0;
    hit_mode = (paddr == qrl_addr(IDX_PORT_MODE));
    hit_stat = (paddr == qrl_addr(IDX_SHAPE_STAT));
    hit_rsvd = (paddr == qrl_addr(IDX_RSVD_BE));
    // Only one limit word can match a given address
    if (paddr == qrl_addr(IDX_P1_LIMIT)) begin
      port_sel = 2'd0;
    end else if (paddr == qrl_addr(IDX_P2_LIMIT)) begin
      port_sel = 2'd1;
    end else if (paddr == qrl_addr(IDX_P3_LIMIT)) begin
      port_sel = 2'd2;
    end else if (paddr == qrl_addr(IDX_P4_LIMIT)) begin
      port_sel = 2'd3;
    end else begin
      hit_limit = 1'b0;
    end
  end

  // Bus answer: prepared in setup, shown in access
  // Read data comes from a flip-flop and holds until the next setup;
  // writes to read-only words are dropped without an error.
  always_comb begin
    pready_next = setup;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    if (setup) begin
      prdata_next = '0;
      // Only unmapped words raise an error
      pslverr_next = !(hit_limit || hit_mode || hit_stat || hit_rsvd);
      if (hit_limit) begin
        // Bit 7 is read-only; identification on port 4 only
        prdata_next[LIMIT_W-1:0] = limit_reg[port_sel];
        prdata_next[ID_BIT] = (port_sel == 2'd3) ? ID_VALUE : 1'b0;
      end else if (hit_mode) begin
        prdata_next[SPEED_LSB+:NUM_PORTS] = speed_reg;
        prdata_next[FOURQ_LSB+:NUM_PORTS] = fourq_reg;
      end else if (hit_stat) begin
        // Shaper eligibility and unlimited state
        prdata_next[0+:NUM_PORTS] = elig;
        prdata_next[NUM_PORTS+:NUM_PORTS] = unl;
      end else begin
        // Reserved and unmapped words read as zero
        prdata_next = '0;
      end
    end else begin
      // Between transfers the last read data stands
      prdata_next = prdata_reg;
    end
  end

  // Register writes take effect at the access edge
  // A shaper keeps its credit across a code change, so the new rate
  // applies from the next tick without a gap in service.
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      limit_next[i] = limit_reg[i];
    end
    speed_next = speed_reg;
    fourq_next = fourq_reg;
    // Writes land once, at the edge that ends the access phase
    if (access && pwrite) begin
      if (hit_limit) begin
        // Only the code field is writable
        limit_next[port_sel] = pwdata[LIMIT_W-1:0];
      end else if (hit_mode) begin
        speed_next = pwdata[SPEED_LSB+:NUM_PORTS];
        fourq_next = pwdata[FOURQ_LSB+:NUM_PORTS];
      end
    end
  end

  // Configuration registers
  // Limits reset to zero, which is the unlimited default code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Speed resets to 100BT, queues to two-queue mode
      for (int i = 0; i < NUM_PORTS; i++) begin
        limit_reg[i] <= LIMIT_RST;
      end
      speed_reg <= SPEED_RST;
      fourq_reg <= FOURQ_RST;
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        limit_reg[i] <= limit_next[i];
      end
      speed_reg <= speed_next;
      fourq_reg <= fourq_next;
    end
  end

  // Bus answer registers
  // pready resets low so no answer shows before the first setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Microsecond tick for credit refill
  // 125 cycles of 8 ns make a microsecond, so a rate in kbps is the
  // credit in millibits added per tick and no divider is needed.
  always_comb begin
    tick_next = 1'b0;
    if (tick_cnt_reg == TICK_CW'(TICK_CYC - 1)) begin
      // Wrap and pulse
      tick_cnt_next = '0;
      tick_next = 1'b1;
    end else begin
      // Count up
      tick_cnt_next = tick_cnt_reg + 1'b1;
    end
  end

  // Tick registers
  // The counter free-runs; shapers only see the registered pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg <= tick_next;
    end
  end

  // One decoder and shaper per port
  // The same decoder serves any limit word, since every limit uses
  // one code format; only the top queue is shaped here.
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    // Same code format for every limit
    qrl_rate_decode u_dec (
      .code(limit_reg[p]),
      .speed_10(speed_reg[p]),
      .unlimited(unl[p]),
      .rate_kbps(rate[p])
    );
    // Credit shaper for the top queue
    // Takes the shared tick and the port's byte pulse
    qrl_shaper u_shp (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick_reg),
      .unlimited(unl[p]),
      .rate_kbps(rate[p]),
      .tx_byte(q3_tx_byte[p]),
      .eligible(elig[p])
    );
  end

  // Grants: queue 3 first, lower queues when it does not take service
  // Grants are registered, so a port may send two more bytes after
  // its credit runs out; the credit goes negative by that much and
  // the average rate still holds.
  always_comb begin
    // Per port, no state shared between ports
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (fourq_reg[i]) begin
        // Top queue wins when shaped credit allows
        // An idle or held-back top queue leaves the slot to the rest
        q3_grant_next[i] = q3_pending[i] && elig[i];
        low_grant_next[i] = low_pending[i] && !q3_grant_next[i];
      end else begin
        // Two-queue mode: queue 3 is not in use
        // Lower queues get every slot; ratios are applied downstream
        q3_grant_next[i] = 1'b0;
        low_grant_next[i] = low_pending[i];
      end
    end
  end

  // Grant registers
  // Grants reset low so no queue sends during reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q3_grant_reg <= '0;
      low_grant_reg <= '0;
    end else begin
      q3_grant_reg <= q3_grant_next;
      low_grant_reg <= low_grant_next;
    end
  end

  // Outputs straight from registers
  // Every output leaves a flip-flop, never the decode logic
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign q3_grant = q3_grant_reg;
  assign low_grant = low_grant_reg;

endmodule

// ===== test/qrl_top_sva.sv
// Purpose: Port checker for the top-queue limit block.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Attached to every qrl_top by the bind at the foot.
`timescale 1ns/1ps

module qrl_top_sva
  import qrl_pkg::*;
#(
  parameter logic ID_VALUE = 1'b0
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [qrl_pkg::APB_AW-1:0] paddr,
  input wire logic [qrl_pkg::APB_DW-1:0] pwdata,
  input wire logic [qrl_pkg::APB_DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Queue side
  input wire logic [qrl_pkg::NUM_PORTS-1:0] q3_pending,
  input wire logic [qrl_pkg::NUM_PORTS-1:0] q3_tx_byte,
  input wire logic [qrl_pkg::NUM_PORTS-1:0] low_pending,
  input wire logic [qrl_pkg::NUM_PORTS-1:0] q3_grant,
  input wire logic [qrl_pkg::NUM_PORTS-1:0] low_grant
);
  // All checks share the bus clock and reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Setup cycle of a transfer
  sequence s_setup;
    psel && !penable;
  endsequence
  // Answered read of one address
  sequence s_rd(logic [9:0] a);
    pready && !pwrite && paddr == a;
  endsequence

  a_ready_setup: assert property (s_setup |=> pready)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("answer longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without answer");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_id_port4: assert property (s_rd(10'h3f8) |-> prdata[7] == ID_VALUE)
    else $error("port 4 identification bit wrong");
  a_id_others: assert property (pready && !pwrite &&
    paddr inside {10'h338, 10'h378, 10'h3b8} |-> !prdata[7])
    else $error("bit 7 not zero on ports 1 to 3");
  a_grant_excl: assert property ((q3_grant & low_grant) == 4'h0)
    else $error("top and lower queues granted together");
  a_q3_cause: assert property ((q3_grant & ~$past(q3_pending)) == 4'h0)
    else $error("top queue granted without a frame");
  a_low_cause: assert property (
    (low_grant & ~$past(low_pending)) == 4'h0)
    else $error("lower queue granted without a frame");
  a_low_served: assert property ((low_pending & ~q3_pending) != 4'h0 |=>
    (low_grant & $past(low_pending & ~q3_pending)) ==
    $past(low_pending & ~q3_pending))
    else $error("idle top queue blocked lower queue");
endmodule

bind qrl_top qrl_top_sva #(.ID_VALUE(ID_VALUE)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .q3_pending(q3_pending),
  .q3_tx_byte(q3_tx_byte), .low_pending(low_pending),
  .q3_grant(q3_grant), .low_grant(low_grant));

// ===== test/qrl_top_tb.sv
// Purpose: Self-checking bench for the top-queue limit block.
// Assumes: APB answers within a bounded wait; tick is 125 cycles.
// Notes: Random register data from a fixed seed.
`timescale 1ns/1ps

module qrl_top_tb;
  import qrl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic [3:0] q3_pending, q3_tx_byte, low_pending, q3_grant, low_grant;
  logic [9:0] lim [4] = '{10'h338, 10'h378, 10'h3b8, 10'h3f8};
  int fail_count, checks, k;

  // Arbitrary identification bit for the device under test
  localparam logic TB_ID = 1'b0;

  qrl_top #(.ID_VALUE(TB_ID)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .q3_pending(q3_pending), .q3_tx_byte(q3_tx_byte),
    .low_pending(low_pending), .q3_grant(q3_grant),
    .low_grant(low_grant));

  // 125 MHz clock
  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end

  // Verdict and end of run
  task automatic stop_test;
    $display("fail_count=%0d checks=%0d", fail_count, checks);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Exact value compare
  task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask

  // Byte count compare within a window
  task automatic cmp_rng(string n, int lo, int hi, int s);
    checks++;
    if (s < lo || s > hi) begin
      fail_count++;
      $display("MISMATCH %s exp %0d..%0d got %0d", n, lo, hi, s);
    end
  endtask

  // One APB transfer; read data and error land in rd and er
  task automatic apb(logic w, logic [9:0] a, logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1) begin
      fail_count++;
      $display("MISMATCH pready exp 1 got %b", pready);
      stop_test;
    end else begin
      psel <= 0;
      penable <= 0;
    end
  endtask

  // Whether a code means no limiting at the given speed
  function automatic logic exp_unl(logic [6:0] c, logic s10);
    logic [6:0] f;
    f = s10 ? 7'd10 : 7'd100;
    return !((c != 0 && c < f) || (c >= 7'd101 && c <= 7'd115));
  endfunction

  // Port 1 top queue sends whenever granted; bytes counted per window
  task automatic rate_run(logic s, logic [6:0] c, int tk);
    int cnt, e;
    logic g, bad;
    apb(1, 10'h100, {24'h0, 7'h08, s});
    apb(1, 10'h338, {25'h0, c});
    cnt = 0;
    bad = 0;
    for (int i = 0; i < 3000 + tk * 125; i++) begin
      @(negedge pclk);
      g = q3_grant[0];
      if ($isunknown(g)) bad = 1;
      @(posedge pclk);
      q3_tx_byte <= {3'h0, g};
      if (i >= 3000) cnt += g;
    end
    @(posedge pclk);
    q3_tx_byte <= 4'h0;
    e = (c == 0) ? tk * 125 : tk * c / 8;
    cmp("grant known", 0, {31'h0, bad});
    cmp_rng("bytes", e - e / tk - 4, e + e / tk + 4, cnt);
  endtask

  // Main sequence
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    q3_pending = 0; q3_tx_byte = 0; low_pending = 0; presetn = 0;
    void'($urandom(32'hf8b4));
    repeat (2) @(posedge pclk);
    presetn <= 1;
    // Reset values
    for (int i = 0; i < 4; i++) begin
      apb(0, lim[i], 0);
      cmp("limit reset", {24'h0, i == 3 && TB_ID, 7'h0}, rd);
    end
    apb(0, 10'h2f8, 0);
    cmp("reserved", 0, rd);
    apb(1, 10'h004, 32'hff);
    apb(0, 10'h004, 0);
    cmp("unmapped err", 1, {31'h0, er});
    cmp("unmapped data", 0, rd);
    // Random writes, bit 7 must not follow
    repeat (8) begin
      k = $urandom_range(3);
      d = $urandom;
      apb(1, lim[k], d);
      apb(0, lim[k], 0);
      cmp("limit", {24'h0, k == 3 && TB_ID, d[6:0]}, rd);
    end
    // Two-queue mode: top queue never granted
    q3_pending <= 4'h5;
    low_pending <= 4'($urandom) | 4'h2;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    cmp("q3 grant", 0, {28'h0, q3_grant});
    cmp("low grant", {28'h0, low_pending}, {28'h0, low_grant});
    // Code sweep at both speeds
    for (int s = 0; s < 2; s++) begin
      apb(1, 10'h100, s);
      for (int c = 0; c < 128; c++) begin
        apb(1, 10'h338, c);
        apb(0, 10'h104, 0);
        cmp("unlimited", exp_unl(7'(c), s[0]), rd[4]);
      end
    end
    // Shaped rates in four-queue mode
    low_pending <= 4'hf;
    rate_run(0, 7'd99, 40);
    rate_run(1, 7'd5, 80);
    rate_run(0, 7'd0, 40);
    stop_test;
  end

  // Watchdog against a hung handshake
  initial begin
    #(80000 * 8);
    fail_count++;
    $display("MISMATCH watchdog exp done got hang");
    stop_test;
  end
endmodule
